// File: bsu_usart.sv
// Synchronous serial transmitter/receiver with mode/command/status ports,
// plus its transmit FIFO. Host port is synchronous to sys_clk_i; modem
// pins and link clocks are asynchronous and sampled here.
//
// Functional notes
// - after any reset the first control write is taken as the mode word.
// - after mode and sync characters, every control write is a command.
// - command bit 6 performs internal reset back to awaiting a mode word.
// - mode bits 2 and 3 select character length 5, 6, 7 or 8.
// - mode bit 4 enables parity generation and checking.
// - mode bit 5 selects parity sense; one means even parity.
// - mode bit 6 makes the sync-detect pin an input.
// - mode bit 7 zero selects double sync character framing.
// - command bit 0 enables the transmitter.
// - command bit 1 drives data terminal ready output inverted.
// - command bit 2 enables the receiver.
// - command bit 4 clears parity and overrun error flags.
// - command bit 5 drives request to send output inverted.
// - command bit 7 starts a hunt for sync characters.
// - data port read gives received byte, write gives byte to send.
// - a read of the control address returns the status word.
// - status bit 0 is ungated ready; ready pin is gated by CTS, enable.
// - status bit 1 is character available; bit 2 means nothing to send.
// - bits 3, 4 flag parity and overrun; overrun loses the new char.
// - status bit 6 rises when sync is found, mid last sync bit.
// - status bit 7 reports data set ready input inverted.

// -------------------------------------------------------------------
// Transmit FIFO
// -------------------------------------------------------------------
module bsu_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = bsu_pkg::FIFO_DEPTH
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             clr_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign in_ready_o  = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o  = mem[rd_ptr];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// Storage; no reset needed, contents qualified by count
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	// Pointers wrap at DEPTH so non-power-of-two depths also work
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else if (clr_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : bsu_fifo

// -------------------------------------------------------------------
// Serial core
// -------------------------------------------------------------------
module bsu_usart #(
	parameter logic [9:0] BASE_DATA = bsu_pkg::DATA_ADDR,
	parameter logic [9:0] BASE_CTRL = bsu_pkg::CTRL_ADDR,
	parameter int         TX_DEPTH  = bsu_pkg::FIFO_DEPTH
) (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	input  wire logic       host_cs_i,
	input  wire logic       host_wr_i,
	input  wire logic       host_rd_i,
	input  wire logic [9:0] host_addr_i,
	input  wire logic [7:0] host_wdata_i,
	output logic      [7:0] host_rdata_o,
	output logic            host_rvalid_o,
	input  wire logic       tx_clk_i,
	input  wire logic       rx_clk_i,
	input  wire logic       rxd_i,
	output logic            txd_o,
	input  wire logic       cts_n_i,
	input  wire logic       dsr_n_i,
	output logic            dtr_n_o,
	output logic            rts_n_o,
	input  wire logic       sync_found_i,
	output logic            sync_found_o,
	output logic            sync_found_oe_o,
	output logic            transmitter_ready_flag_o,
	output logic            receive_char_available_o,
	output logic            transmitter_drained_o
);
	// ---------------------------------------------------------------
	// Helper functions
	// ---------------------------------------------------------------
	function automatic logic [3:0] char_len(input logic [7:0] m);
		char_len = bsu_pkg::MIN_CHAR_LEN
			+ {2'b00, m[bsu_pkg::MODE_LEN_HI], m[bsu_pkg::MODE_LEN_LO]};
	endfunction : char_len

	function automatic logic [3:0] frame_len(input logic [7:0] m);
		frame_len = char_len(m) + {3'b000, m[bsu_pkg::MODE_PAR_EN]};
	endfunction : frame_len

	function automatic logic [7:0] char_mask(input logic [3:0] n);
		char_mask = 8'hFF >> (bsu_pkg::MAX_CHAR_LEN - n);
	endfunction : char_mask

	// Parity bit value that makes the frame match the selected sense
	function automatic logic par_bit(input logic [7:0] d,
			input logic [7:0] m);
		par_bit = (^d) ^ ~m[bsu_pkg::MODE_PAR_EVEN];
	endfunction : par_bit

	// Last n received bits, right aligned (bits arrive LSB first)
	function automatic logic [8:0] tail(input logic [8:0] w,
			input logic [3:0] n);
		tail = w >> (bsu_pkg::FRAME_W - n);
	endfunction : tail

	// ---------------------------------------------------------------
	// Input synchronisers and edge detect
	// ---------------------------------------------------------------
	logic [bsu_pkg::AS_W-1:0] as_meta;
	logic [bsu_pkg::AS_W-1:0] as_sync;
	logic [bsu_pkg::AS_W-1:0] as_last;

	// First stage feeds only the second; edges come from stage two
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			as_meta <= '0;
			as_sync <= '0;
			as_last <= '0;
		end else begin
			as_meta <= {sync_found_i, dsr_n_i, cts_n_i, rxd_i, rx_clk_i,
				tx_clk_i};
			as_sync <= as_meta;
			as_last <= as_sync;
		end
	end

	logic txc_fall;
	logic rxc_rise;
	logic ext_sync_rise;
	logic rx_bit;
	assign txc_fall = as_last[bsu_pkg::AS_TXC] && !as_sync[bsu_pkg::AS_TXC];
	assign rxc_rise = !as_last[bsu_pkg::AS_RXC] && as_sync[bsu_pkg::AS_RXC];
	assign ext_sync_rise = !as_last[bsu_pkg::AS_SYN]
		&& as_sync[bsu_pkg::AS_SYN];
	assign rx_bit = as_sync[bsu_pkg::AS_RXD];

	// ---------------------------------------------------------------
	// Host access decode
	// ---------------------------------------------------------------
	logic ctrl_wr;
	logic data_wr;
	logic ctrl_rd;
	logic data_rd;
	assign ctrl_wr = host_cs_i && host_wr_i && (host_addr_i == BASE_CTRL);
	assign data_wr = host_cs_i && host_wr_i && (host_addr_i == BASE_DATA);
	assign ctrl_rd = host_cs_i && host_rd_i && !host_wr_i
		&& (host_addr_i == BASE_CTRL);
	assign data_rd = host_cs_i && host_rd_i && !host_wr_i
		&& (host_addr_i == BASE_DATA);

	// ---------------------------------------------------------------
	// Configuration sequencer
	// ---------------------------------------------------------------
	bsu_pkg::bsu_cfg_e cfg_state;
	logic [7:0]        mode;
	logic [7:0]        cmd;
	logic [7:0]        sync1;
	logic [7:0]        sync2;
	logic              cmd_wr;
	logic              ireset;
	assign cmd_wr = ctrl_wr && (cfg_state == bsu_pkg::CFG_CMD);
	assign ireset = cmd_wr && host_wdata_i[bsu_pkg::CMD_IRESET];

	// Mode, then one or two sync characters, then commands until an internal reset
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_state <= bsu_pkg::CFG_MODE;
			mode      <= bsu_pkg::MODE_RESET;
			sync1     <= bsu_pkg::SYNC_RESET;
			sync2     <= bsu_pkg::SYNC_RESET;
		end else if (ctrl_wr) begin
			case (cfg_state)
				bsu_pkg::CFG_MODE: begin
					mode      <= host_wdata_i;
					cfg_state <= bsu_pkg::CFG_SYNC1;
				end
				bsu_pkg::CFG_SYNC1: begin
					sync1     <= host_wdata_i;
					cfg_state <= mode[bsu_pkg::MODE_SINGLE_SYNC]
						? bsu_pkg::CFG_CMD : bsu_pkg::CFG_SYNC2;
				end
				bsu_pkg::CFG_SYNC2: begin
					sync2     <= host_wdata_i;
					cfg_state <= bsu_pkg::CFG_CMD;
				end
				bsu_pkg::CFG_CMD: begin
					if (host_wdata_i[bsu_pkg::CMD_IRESET]) begin
						cfg_state <= bsu_pkg::CFG_MODE;
					end
				end
				default: cfg_state <= bsu_pkg::CFG_MODE;
			endcase
		end
	end

	// Command register; internal reset drops every enable
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmd <= bsu_pkg::CMD_RESET;
		end else if (ireset) begin
			cmd <= bsu_pkg::CMD_RESET;
		end else if (cmd_wr) begin
			cmd <= host_wdata_i;
		end
	end

	logic tx_en;
	logic rx_en;
	assign tx_en = cmd[bsu_pkg::CMD_TX_EN];
	assign rx_en = cmd[bsu_pkg::CMD_RX_EN];

	// ---------------------------------------------------------------
	// Transmit path
	// ---------------------------------------------------------------
	logic       fifo_in_ready;
	logic       fifo_valid;
	logic [7:0] fifo_data;
	logic       fifo_pop;
	logic [8:0] tx_shift;
	logic [3:0] tx_left;
	logic       tx_data_char;
	logic       tx_sync_sel;
	logic       tx_active;
	logic [7:0] tx_char;
	logic [8:0] tx_word;

	// Transmission needs both enable and clear-to-send (active low)
	assign tx_active = tx_en && !as_sync[bsu_pkg::AS_CTS];
	assign fifo_pop  = txc_fall && (tx_left == '0) && tx_active;
	assign tx_char   = (fifo_valid ? fifo_data
		: (tx_sync_sel ? sync2 : sync1)) & char_mask(char_len(mode));
	assign tx_word   = {1'b0, tx_char}
		| (mode[bsu_pkg::MODE_PAR_EN]
			? (9'(par_bit(tx_char, mode)) << char_len(mode)) : 9'h000);

	bsu_fifo #(
		.WIDTH (8),
		.DEPTH (TX_DEPTH)
	) u_tx_fifo (
		.clk_i       (sys_clk_i),
		.rst_i       (rst_i),
		.clr_i       (ireset),
		.in_valid_i  (data_wr && (cfg_state == bsu_pkg::CFG_CMD)),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (host_wdata_i),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_pop),
		.out_data_o  (fifo_data)
	);

	// Shifter changes the line on the falling link clock edge; with no
	// queued data and the transmitter active, the line is filled with sync characters, as a sync
	// receiver would otherwise lose character framing
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_shift     <= '0;
			tx_left      <= '0;
			tx_data_char <= 1'b0;
			tx_sync_sel  <= 1'b0;
			txd_o        <= 1'b1;
		end else if (ireset) begin
			tx_left      <= '0;
			tx_data_char <= 1'b0;
			tx_sync_sel  <= 1'b0;
			txd_o        <= 1'b1;
		end else if (txc_fall) begin
			if (tx_left != '0) begin
				txd_o    <= tx_shift[0];
				tx_shift <= tx_shift >> 1;
				tx_left  <= tx_left - 4'h1;
			end else if (tx_active) begin
				txd_o        <= tx_word[0];
				tx_shift     <= tx_word >> 1;
				tx_left      <= frame_len(mode) - 4'h1;
				tx_data_char <= fifo_valid;
				if (!fifo_valid) begin
					tx_sync_sel <= !mode[bsu_pkg::MODE_SINGLE_SYNC]
						&& !tx_sync_sel;
				end
			end else begin
				txd_o        <= 1'b1;
				tx_data_char <= 1'b0;
			end
			if (cmd[bsu_pkg::CMD_BREAK]) begin
				txd_o <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Receive path
	// ---------------------------------------------------------------
	bsu_pkg::bsu_rx_e rx_state;
	logic [8:0]       rx_win;
	logic [8:0]       rx_next_win;
	logic [8:0]       rx_frame;
	logic [3:0]       rx_cnt;
	logic             rx_done;
	logic [7:0]       rx_char;
	logic             rx_perr;
	logic             sync_hit;
	logic             ext_sync;

	assign ext_sync    = mode[bsu_pkg::MODE_EXT_SYNC];
	assign rx_next_win = {rx_bit, rx_win[8:1]};
	assign rx_frame    = tail(rx_next_win, frame_len(mode));

	// Hunt, then framed reception; sync found is flagged on the very
	// sample that completes the last sync character, mid bit
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_state <= bsu_pkg::RX_IDLE;
			rx_win   <= '0;
			rx_cnt   <= '0;
			rx_done  <= 1'b0;
			rx_char  <= '0;
			rx_perr  <= 1'b0;
			sync_hit <= 1'b0;
		end else begin
			rx_done  <= 1'b0;
			sync_hit <= 1'b0;
			// Hunt and enable often share one write; use its new enable
			if (ireset) begin
				rx_state <= bsu_pkg::RX_IDLE;
			end else if (cmd_wr && host_wdata_i[bsu_pkg::CMD_HUNT]
					&& host_wdata_i[bsu_pkg::CMD_RX_EN]) begin
				rx_state <= bsu_pkg::RX_SEEK;
				rx_cnt   <= '0;
			end else if (!rx_en) begin
				rx_state <= bsu_pkg::RX_IDLE;
			end else if (ext_sync && ext_sync_rise
					&& ((rx_state == bsu_pkg::RX_SEEK)
					|| (rx_state == bsu_pkg::RX_SEEK2))) begin
				rx_state <= bsu_pkg::RX_DATA;
				rx_cnt   <= '0;
				sync_hit <= 1'b1;
			end else if (rxc_rise) begin
				rx_win <= rx_next_win;
				case (rx_state)
					bsu_pkg::RX_IDLE: begin
						if (rx_en) begin
							rx_state <= bsu_pkg::RX_DATA;
							rx_cnt   <= '0;
						end
					end
					bsu_pkg::RX_SEEK: begin
						if (!ext_sync && ((rx_frame[7:0]
								& char_mask(char_len(mode)))
								== (sync1 & char_mask(char_len(mode))))) begin
							rx_cnt <= '0;
							if (mode[bsu_pkg::MODE_SINGLE_SYNC]) begin
								rx_state <= bsu_pkg::RX_DATA;
								sync_hit <= 1'b1;
							end else begin
								rx_state <= bsu_pkg::RX_SEEK2;
							end
						end
					end
					bsu_pkg::RX_SEEK2: begin
						rx_cnt <= rx_cnt + 4'h1;
						if (rx_cnt == frame_len(mode) - 4'h1) begin
							rx_cnt <= '0;
							if ((rx_frame[7:0] & char_mask(char_len(mode)))
									== (sync2 & char_mask(char_len(mode)))) begin
								rx_state <= bsu_pkg::RX_DATA;
								sync_hit <= 1'b1;
							end else begin
								rx_state <= bsu_pkg::RX_SEEK;
							end
						end
					end
					bsu_pkg::RX_DATA: begin
						rx_cnt <= rx_cnt + 4'h1;
						if (rx_cnt == frame_len(mode) - 4'h1) begin
							rx_cnt  <= '0;
							rx_done <= 1'b1;
							rx_char <= rx_frame[7:0] & char_mask(char_len(mode));
							rx_perr <= mode[bsu_pkg::MODE_PAR_EN]
								&& (rx_frame[char_len(mode)] != par_bit(
								rx_frame[7:0] & char_mask(char_len(mode)),
								mode));
						end
					end
					default: rx_state <= bsu_pkg::RX_IDLE;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Receive holding register and sticky status
	// ---------------------------------------------------------------
	logic [7:0] rx_hold;
	logic       rx_avail;
	logic       par_err;
	logic       overrun;
	logic       sync_flag;
	logic       err_clr;
	assign err_clr = cmd_wr && host_wdata_i[bsu_pkg::CMD_ERR_RST];

	// New character wins over a same-cycle read; unread hold is kept
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_hold  <= '0;
			rx_avail <= 1'b0;
		end else if (ireset) begin
			rx_avail <= 1'b0;
		end else if (rx_done && (!rx_avail || data_rd)) begin
			rx_hold  <= rx_char;
			rx_avail <= 1'b1;
		end else if (data_rd) begin
			rx_avail <= 1'b0;
		end
	end

	// Error flags: a fresh error beats the clear in the same cycle
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			par_err <= 1'b0;
			overrun <= 1'b0;
		end else if (ireset) begin
			par_err <= 1'b0;
			overrun <= 1'b0;
		end else begin
			if (rx_done && rx_perr) begin
				par_err <= 1'b1;
			end else if (err_clr) begin
				par_err <= 1'b0;
			end
			if (rx_done && rx_avail && !data_rd) begin
				overrun <= 1'b1;
			end else if (err_clr) begin
				overrun <= 1'b0;
			end
		end
	end

	// Sync flag clears on a status read or while in RX_SEEK, unless a new hit lands then
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync_flag <= 1'b0;
		end else if (ireset) begin
			sync_flag <= 1'b0;
		end else if (sync_hit) begin
			sync_flag <= 1'b1;
		end else if (ctrl_rd || (rx_state == bsu_pkg::RX_SEEK)) begin
			sync_flag <= 1'b0;
		end
	end

	logic [7:0] status;
	always_comb begin
		status                       = '0;
		status[bsu_pkg::ST_TX_READY] = fifo_in_ready;
		status[bsu_pkg::ST_RX_AVAIL] = rx_avail;
		status[bsu_pkg::ST_DRAINED]  = !fifo_valid && !tx_data_char;
		status[bsu_pkg::ST_PAR_ERR]  = par_err;
		status[bsu_pkg::ST_OVERRUN]  = overrun;
		status[bsu_pkg::ST_FRAMING]  = 1'b0;
		status[bsu_pkg::ST_SYNC]     = sync_flag;
		status[bsu_pkg::ST_DSR]      = !as_sync[bsu_pkg::AS_DSR];
	end

	// ---------------------------------------------------------------
	// Host read data and registered pins
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			host_rdata_o  <= '0;
			host_rvalid_o <= 1'b0;
		end else begin
			host_rvalid_o <= ctrl_rd || data_rd;
			if (ctrl_rd) begin
				host_rdata_o <= status;
			end else if (data_rd) begin
				host_rdata_o <= rx_hold;
			end
		end
	end

	// Modem and flag pins, all straight from flops
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dtr_n_o                  <= 1'b1;
			rts_n_o                  <= 1'b1;
			sync_found_o             <= 1'b0;
			sync_found_oe_o          <= 1'b0;
			transmitter_ready_flag_o <= 1'b0;
			receive_char_available_o <= 1'b0;
			transmitter_drained_o    <= 1'b1;
		end else begin
			dtr_n_o                  <= !cmd[bsu_pkg::CMD_DTR];
			rts_n_o                  <= !cmd[bsu_pkg::CMD_RTS];
			sync_found_o             <= sync_flag;
			sync_found_oe_o          <= !ext_sync;
			transmitter_ready_flag_o <= fifo_in_ready && tx_active;
			receive_char_available_o <= rx_avail;
			transmitter_drained_o    <= status[bsu_pkg::ST_DRAINED];
		end
	end

endmodule : bsu_usart

// File: bsu_pkg.sv
// Constants, field positions and state codes for the sync serial block.
// Assumes the host decodes its 10-bit I/O address onto this block alone.

package bsu_pkg;

	// ---------------------------------------------------------------
	// Port addresses
	// ---------------------------------------------------------------
	localparam logic [9:0] DATA_ADDR = 10'h3A8;
	localparam logic [9:0] CTRL_ADDR = 10'h3A9;

	// ---------------------------------------------------------------
	// Mode word fields
	// ---------------------------------------------------------------
	localparam int MODE_LEN_LO      = 2;
	localparam int MODE_LEN_HI      = 3;
	localparam int MODE_PAR_EN      = 4;
	localparam int MODE_PAR_EVEN    = 5;
	localparam int MODE_EXT_SYNC    = 6;
	localparam int MODE_SINGLE_SYNC = 7;

	// ---------------------------------------------------------------
	// Command word fields
	// ---------------------------------------------------------------
	localparam int CMD_TX_EN   = 0;
	localparam int CMD_DTR     = 1;
	localparam int CMD_RX_EN   = 2;
	localparam int CMD_BREAK   = 3;
	localparam int CMD_ERR_RST = 4;
	localparam int CMD_RTS     = 5;
	localparam int CMD_IRESET  = 6;
	localparam int CMD_HUNT    = 7;

	// ---------------------------------------------------------------
	// Status word fields
	// ---------------------------------------------------------------
	localparam int ST_TX_READY = 0;
	localparam int ST_RX_AVAIL = 1;
	localparam int ST_DRAINED  = 2;
	localparam int ST_PAR_ERR  = 3;
	localparam int ST_OVERRUN  = 4;
	localparam int ST_FRAMING  = 5;
	localparam int ST_SYNC     = 6;
	localparam int ST_DSR      = 7;

	// ---------------------------------------------------------------
	// Sizes and reset values
	// ---------------------------------------------------------------
	localparam logic [3:0] MIN_CHAR_LEN = 4'h5;
	localparam logic [3:0] MAX_CHAR_LEN = 4'h8;
	localparam logic [3:0] FRAME_W      = 4'h9;
	localparam logic [7:0] MODE_RESET   = 8'h00;
	localparam logic [7:0] CMD_RESET    = 8'h00;
	localparam logic [7:0] SYNC_RESET   = 8'h32;
	localparam int         FIFO_DEPTH   = 4;

	// Index of each outside-domain input in the synchroniser vector
	localparam int AS_TXC = 0;
	localparam int AS_RXC = 1;
	localparam int AS_RXD = 2;
	localparam int AS_CTS = 3;
	localparam int AS_DSR = 4;
	localparam int AS_SYN = 5;
	localparam int AS_W   = 6;

	typedef enum logic [1:0] {
		CFG_MODE  = 2'b00,
		CFG_SYNC1 = 2'b01,
		CFG_SYNC2 = 2'b10,
		CFG_CMD   = 2'b11
	} bsu_cfg_e;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_SEEK  = 2'b01,
		RX_SEEK2 = 2'b10,
		RX_DATA  = 2'b11
	} bsu_rx_e;

endpackage : bsu_pkg

// File: bsu_usart_properties.sv
// Timing checker for the sync serial block host port and modem pins.
// Assumes it is bound to bsu_usart and sees only that module's ports.
module bsu_usart_properties (
	input wire logic       sys_clk_i,
	input wire logic       rst_i,
	input wire logic       host_cs_i,
	input wire logic       host_wr_i,
	input wire logic       host_rd_i,
	input wire logic [9:0] host_addr_i,
	input wire logic [7:0] host_wdata_i,
	input wire logic [7:0] host_rdata_o,
	input wire logic       host_rvalid_o,
	input wire logic       cts_n_i,
	input wire logic       dsr_n_i,
	input wire logic       dtr_n_o,
	input wire logic       rts_n_o,
	input wire logic       sync_found_oe_o,
	input wire logic       transmitter_ready_flag_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	logic [1:0] phase;
	logic [7:0] mode;
	wire logic ctl = host_addr_i == bsu_pkg::CTRL_ADDR;
	wire logic cw  = host_cs_i & host_wr_i & ctl;
	wire logic rc  = host_cs_i & host_rd_i & !host_wr_i & ctl;
	wire logic cmd = cw & (phase == 2'h3);
	// Phase of control writes, so commands are known without peeking inside
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			phase <= 2'h0;
			mode  <= 8'h00;
		end else if (cw) begin
			if (phase == 2'h0) mode <= host_wdata_i;
			phase <= (phase == 2'h0) ? 2'h1 :
				(phase == 2'h1 && !mode[7]) ? 2'h2 :
				(phase == 2'h3 && host_wdata_i[6]) ? 2'h0 : 2'h3;
		end
	end
	a_read_answers: assert property (rc |=> host_rvalid_o)
		else $error("no status answer");
	a_answer_cause: assert property (
		host_rvalid_o |-> $past(host_cs_i & host_rd_i))
		else $error("answer without read");
	a_cts_gates_ready: assert property (
		cts_n_i [*4] |-> !transmitter_ready_flag_o)
		else $error("ready pin without cts");
	a_status_dsr: assert property (
		$stable(dsr_n_i) [*3] ##0 rc |=>
		host_rdata_o[bsu_pkg::ST_DSR] == !$past(dsr_n_i))
		else $error("dsr status bit");
	a_rts_from_cmd: assert property (
		cmd && !host_wdata_i[6] |=> ##1 rts_n_o == !$past(host_wdata_i[5], 2))
		else $error("rts pin");
	a_dtr_from_cmd: assert property (
		cmd && !host_wdata_i[6] |=> ##1 dtr_n_o == !$past(host_wdata_i[1], 2))
		else $error("dtr pin");
	a_mode_sets_pin: assert property (
		cw && phase == 2'h0 |=> ##1 sync_found_oe_o == !$past(host_wdata_i[6], 2))
		else $error("sync pin direction");
	a_ireset_clears: assert property (
		cmd && host_wdata_i[6] |=> ##1 rts_n_o && dtr_n_o)
		else $error("internal reset");
endmodule : bsu_usart_properties

bind bsu_usart bsu_usart_properties chk_u (.*);

// File: bsu_modem.sv
// Modem model: link clocks, received bit stream, record of sent bits.
// Assumes the block shifts txd on falling and samples rxd on rising clock.
module bsu_modem (
	input  wire logic txd_i,
	output logic      tx_clk_o,
	output logic      rx_clk_o,
	output logic      rxd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [63:0] hist;
	bit          q[$];
	// Sync modem clocks run all the time, phase unrelated to the host clock
	initial begin
		tx_clk_o = 1'b1;
		#37;
		forever #80 tx_clk_o = ~tx_clk_o;
	end
	assign rx_clk_o = ~tx_clk_o;
	// Mark fill when nothing is queued
	always @(negedge rx_clk_o) rxd_o <= (q.size() != 0) ? q.pop_front() : 1'b1;
	// Newest bit on top, so a character sent LSB first reads in place
	always @(posedge tx_clk_o) hist <= {txd_i, hist[63:1]};
	task automatic send(input logic [7:0] b);
		for (int i = 0; i < 8; i++) q.push_back(b[i]);
	endtask : send
endmodule : bsu_modem

// File: bsu_usart_tb.sv
// Self-checking bench for the sync serial block against a modem model.
// Assumes bsu_usart, bsu_modem and the bound checker are compiled first.
module bsu_usart_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [9:0] DP = 10'h3A8;
	localparam logic [9:0] CP = 10'h3A9;
	localparam logic [7:0] SY = 8'h32;
	logic        sys_clk_i, rst_i, cs, wr, rd, cts_n, dsr_n, sfi;
	logic        rvalid, txd, txc, rxc, rxd, rdy, avail, drained;
	logic        dtr_n, rts_n, sfo;
	logic [9:0]  addr;
	logic [7:0]  wdata, rdata, s, m, d;
	logic [7:0]  v[$];
	logic [63:0] p;
	int          fails, comparisons;
	bsu_usart dut_u (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .host_cs_i(cs),
		.host_wr_i(wr), .host_rd_i(rd), .host_addr_i(addr),
		.host_wdata_i(wdata), .host_rdata_o(rdata), .host_rvalid_o(rvalid),
		.tx_clk_i(txc), .rx_clk_i(rxc), .rxd_i(rxd), .txd_o(txd),
		.cts_n_i(cts_n), .dsr_n_i(dsr_n), .dtr_n_o(dtr_n), .rts_n_o(rts_n),
		.sync_found_i(sfi), .sync_found_o(sfo), .sync_found_oe_o(),
		.transmitter_ready_flag_o(rdy), .receive_char_available_o(avail),
		.transmitter_drained_o(drained)
	);
	bsu_modem modem_u (.txd_i(txd), .tx_clk_o(txc), .rx_clk_o(rxc),
		.rxd_o(rxd));
	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	task automatic put(input logic [9:0] a, input logic [7:0] x);
		@(negedge sys_clk_i);
		{cs, wr, addr, wdata} = {2'b11, a, x};
		@(negedge sys_clk_i);
		{cs, wr} = 2'b00;
	endtask : put
	// Answer is read half a cycle after the taken edge
	task automatic get(input logic [9:0] a, output logic [7:0] x);
		@(negedge sys_clk_i);
		{cs, rd, addr} = {2'b11, a};
		@(negedge sys_clk_i);
		{cs, rd} = 2'b00;
		x = rdata;
	endtask : get
	task automatic chk(input logic [7:0] g, input logic [7:0] e, string t);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: %s %h/%h", $time, t, g, e);
		end
	endtask : chk
	task automatic cfg(input logic [7:0] mw, input logic [7:0] c);
		put(CP, mw);
		put(CP, SY);
		if (!mw[7]) put(CP, SY);
		put(CP, c);
	endtask : cfg
	// Looks for a bit pattern anywhere in the recorded line
	function automatic logic seen(input logic [63:0] f, input int w);
		logic [63:0] k;
		k = (64'h1 << w) - 64'h1;
		seen = 1'b0;
		for (int i = 0; i + w <= 64; i++)
			if (((modem_u.hist >> i) & k) === f) seen = 1'b1;
	endfunction : seen
	task automatic close_out();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : close_out
	initial begin
		#200000;
		fails++;
		close_out();
	end
	initial begin
		{cs, wr, rd, addr, wdata, sfi, cts_n, dsr_n} = '0;
		rst_i = 1'b1;
		void'($urandom(94));
		repeat (3) @(posedge sys_clk_i);
		@(negedge sys_clk_i) rst_i = 1'b0;
		// Every length, parity sense flipping, data behind a sync char
		for (int l = 5; l <= 8; l++) begin
			m = {l[1], l[1] ^ l[0], l[0], 1'b1, 2'(l - 5), 2'b00};
			cfg(m, 8'h23);
			repeat (2) @(posedge txc);
			d = 8'($urandom);
			put(DP, d);
			repeat (3 * l + 8) @(posedge txc);
			d = d & 8'((9'h1 << l) - 9'h1);
			s = SY & 8'((9'h1 << l) - 9'h1);
			p = 64'(s) | 64'(^s ^ !m[5]) << l | 64'(d) << (l + 1)
				| 64'(^d ^ !m[5]) << (2 * l + 1);
			chk({7'h0, seen(p, 2 * l + 2)}, 8'h01, "frame");
			chk({7'h0, rdy}, 8'h01, "rdy");
			put(CP, 8'h40);
		end
		$display("test frames done");
		// Fill while the modem stalls, then drain in order
		cts_n = 1'b1;
		cfg(8'h0C, 8'h01);
		for (int i = 0; i < 5; i++) begin
			v.push_back(8'($urandom));
			put(DP, v[i]);
		end
		get(CP, s);
		chk(s & 8'h01, 8'h00, "full");
		chk({7'h0, rdy}, 8'h00, "stall");
		cts_n = 1'b0;
		repeat (48) @(posedge txc);
		chk({7'h0, seen({32'h0, v[3], v[2], v[1], v[0]}, 32)}, 8'h01, "order");
		get(CP, s);
		chk({drained, s[6:0]} & 8'h85, 8'h85, "drain");
		put(CP, 8'h40);
		$display("test fifo done");
		// Hunt, receive, overrun, error reset
		dsr_n = 1'($urandom);
		cfg(8'h0C, 8'h94);
		v = {8'($urandom), 8'($urandom), 8'($urandom)};
		modem_u.send(SY);
		modem_u.send(SY);
		for (int i = 0; i < 3; i++) modem_u.send(v[i]);
		wait (modem_u.q.size() == 16);
		@(posedge rxc);
		repeat (10) @(negedge sys_clk_i);
		get(CP, s);
		chk(s & 8'hDB | 8'(sfo) << 5, {!dsr_n, 7'h63}, "hunt");
		chk({7'h0, avail}, 8'h01, "avail");
		get(DP, s);
		chk(s, v[0], "rx");
		wait (modem_u.q.size() == 0);
		@(posedge rxc);
		repeat (10) @(negedge sys_clk_i);
		get(CP, s);
		chk(s & 8'h12, 8'h12, "ovr");
		get(DP, s);
		chk(s, v[1], "kept");
		get(10'h3A7, s);
		chk(s, v[1], "unmapped");
		put(CP, 8'h14);
		get(CP, s);
		chk(s & 8'h18, 8'h00, "errrst");
		$display("test receive done");
		close_out();
	end
endmodule : bsu_usart_tb
